//--- adc_cal_pkg.sv
`default_nettype none
package adc_cal_pkg;
  localparam int CODE_W = 20;
  localparam int RAW_W = 24;
  localparam int CNT_W = 22;
  localparam int NUM_W = 48;
  localparam int QUOT_W = 22;
  localparam int IRQ_W = 3;
  localparam int unsigned SELF_CAL_LEN = 3145655;
  localparam int unsigned SYS_OFFSET_LEN = 1052599;
  localparam int unsigned SYS_GAIN_LEN = 1068813;
  localparam int unsigned ONE_STEP_LEN = 2117389;
  localparam logic [2:0] TRIG_MIN_HIGH = 3'h4;
  localparam int UNI_SHIFT = 20;
  localparam int BIP_SHIFT = 19;
  localparam logic [CODE_W-1:0] CODE_ZERO = 20'h00000;
  localparam logic [CODE_W-1:0] CODE_FULL = 20'hfffff;
  localparam logic [CODE_W-1:0] CODE_MID = 20'h80000;
  localparam logic [CODE_W-1:0] CODE_HALF_MAX = 20'h7ffff;
  localparam logic [1:0] INSEL_AIN = 2'h0;
  localparam logic [1:0] INSEL_ANALOG_GROUND_LEVEL = 2'h1;
  localparam logic [1:0] INSEL_REF = 2'h2;
  localparam logic [RAW_W-1:0] ZERO_COEF_RESET = 24'h000000;
  localparam logic [RAW_W-1:0] FULL_COEF_RESET = 24'h400000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_ZERO_COEF = 8'h18;
  localparam logic [7:0] ADDR_FULL_COEF = 8'h1c;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SEL_SECOND_BIT = 1;
  localparam int CTRL_SEL_FIRST_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WORD_READY_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_POL_BIT = 4;
  localparam int IRQ_CAL_DONE_BIT = 0;
  localparam int IRQ_NEW_WORD_BIT = 1;
  localparam int IRQ_REJECT_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;
  localparam logic [1:0] SW_SEL_RESET = 2'h0;

  typedef enum logic [1:0] {CAL_SELF, CAL_SYS_OFFSET, CAL_SYS_GAIN, CAL_ONE_STEP} cal_mode_type;
  typedef enum logic [1:0] {ST_RUN, ST_CAL, ST_SETTLE} seq_state_type;

  function automatic cal_mode_type decode_mode(input logic first, input logic second);
    case ({first, second})
      2'h0: decode_mode = CAL_SELF;
      2'h3: decode_mode = CAL_SYS_OFFSET;
      2'h1: decode_mode = CAL_SYS_GAIN;
      default: decode_mode = CAL_ONE_STEP;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- adc_calibration_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_sequencer
  import adc_cal_pkg::*;
#(
  parameter int unsigned SELF_CAL_CYCLES = SELF_CAL_LEN,
  parameter int unsigned SYS_OFFSET_CYCLES = SYS_OFFSET_LEN,
  parameter int unsigned SYS_GAIN_CYCLES = SYS_GAIN_LEN,
  parameter int unsigned ONE_STEP_CYCLES = ONE_STEP_LEN
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CAL_TRIGGER_I,
  input wire logic CAL_SELECT_FIRST_I,
  input wire logic CAL_SELECT_SECOND_I,
  input wire logic POLARITY_SELECT_I,
  input wire logic [RAW_W-1:0] RAW_DATA_I,
  input wire logic RAW_VALID_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic WORD_READY_N_O,
  output logic [CODE_W-1:0] DATA_O,
  output logic [1:0] INPUT_SEL_O,
  output logic IRQ_O
);
  cal_ctrl_if ctl ();

  seq_state_type state_reg;
  cal_mode_type mode_reg;
  cal_mode_type start_mode;
  logic [CNT_W-1:0] cal_cnt_reg;
  logic [CNT_W-1:0] cal_last_reg;
  logic [CNT_W-1:0] cal_last_next;
  logic cal_start;
  logic cal_end;
  logic zero_phase;
  logic full_phase;
  logic sw_go_reg;
  logic [1:0] sw_sel_reg;
  logic [RAW_W-1:0] zero_reg;
  logic [RAW_W-1:0] full_reg;
  logic [1:0] insel_next;
  logic signed [RAW_W:0] diff;
  logic signed [RAW_W:0] span;
  logic [RAW_W:0] mag;
  logic [RAW_W:0] den;
  logic [NUM_W-1:0] num;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic div_sat;
  logic [QUOT_W-1:0] div_quot;
  logic neg_reg;
  logic bip_reg;
  logic owned_reg;
  logic load_word;
  logic [CODE_W-1:0] conv_code;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic bus_take;
  logic bus_wr;
  logic [31:0] rdata_next;

  cal_trigger trigger_unit (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .trig_i(CAL_TRIGGER_I),
    .sel_first_i(CAL_SELECT_FIRST_I),
    .sel_second_i(CAL_SELECT_SECOND_I),
    .ctl(ctl)
  );

  code_divider divider_unit (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .start_i(div_start),
    .num_i(num),
    .den_i(den),
    .busy_o(div_busy),
    .done_o(div_done),
    .sat_o(div_sat),
    .quot_o(div_quot)
  );

  assign ctl.busy = state_reg != ST_RUN;
  assign cal_start = (ctl.start || sw_go_reg) && state_reg == ST_RUN;
  assign cal_end = state_reg == ST_CAL && cal_cnt_reg == cal_last_reg;

  always_comb begin
    start_mode = ctl.start ? decode_mode(ctl.sel_first, ctl.sel_second)
                           : decode_mode(sw_sel_reg[1], sw_sel_reg[0]);
    case (start_mode)
      CAL_SELF: cal_last_next = CNT_W'(SELF_CAL_CYCLES - 1);
      CAL_SYS_OFFSET: cal_last_next = CNT_W'(SYS_OFFSET_CYCLES - 1);
      CAL_SYS_GAIN: cal_last_next = CNT_W'(SYS_GAIN_CYCLES - 1);
      default: cal_last_next = CNT_W'(ONE_STEP_CYCLES - 1);
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= ST_RUN;
      mode_reg <= CAL_SELF;
      cal_cnt_reg <= '0;
      cal_last_reg <= '0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (cal_start) begin
            state_reg <= ST_CAL;
            mode_reg <= start_mode;
            cal_last_reg <= cal_last_next;
            cal_cnt_reg <= '0;
          end
        end
        ST_CAL: begin
          cal_cnt_reg <= cal_cnt_reg + CNT_W'(1);
          if (cal_end) begin
            state_reg <= (mode_reg == CAL_SELF) ? ST_SETTLE : ST_RUN;
          end
        end
        ST_SETTLE: begin
          if (load_word) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  always_comb begin
    zero_phase = 1'b0;
    full_phase = 1'b0;
    insel_next = INSEL_AIN;
    if (state_reg == ST_CAL) begin
      case (mode_reg)
        CAL_SYS_OFFSET: zero_phase = 1'b1;
        CAL_SYS_GAIN: full_phase = 1'b1;
        default: begin
          zero_phase = cal_cnt_reg < (cal_last_reg >> 1);
          full_phase = !zero_phase;
        end
      endcase
      if (mode_reg == CAL_SELF) begin
        insel_next = zero_phase ? INSEL_ANALOG_GROUND_LEVEL : INSEL_REF;
      end else if (mode_reg == CAL_ONE_STEP && full_phase) begin
        insel_next = INSEL_REF;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      INPUT_SEL_O <= INSEL_AIN;
    end else begin
      INPUT_SEL_O <= insel_next;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      zero_reg <= ZERO_COEF_RESET;
      full_reg <= FULL_COEF_RESET;
    end else if (RAW_VALID_I && zero_phase && INPUT_SEL_O == insel_next) begin
      zero_reg <= RAW_DATA_I;
    end else if (RAW_VALID_I && full_phase && INPUT_SEL_O == insel_next) begin
      full_reg <= RAW_DATA_I;
    end
  end

  always_comb begin
    diff = $signed({RAW_DATA_I[RAW_W-1], RAW_DATA_I}) - $signed({zero_reg[RAW_W-1], zero_reg});
    span = $signed({full_reg[RAW_W-1], full_reg}) - $signed({zero_reg[RAW_W-1], zero_reg});
    mag = diff[RAW_W] ? (RAW_W+1)'(0) - diff : diff;
    den = (span[RAW_W] || span == '0) ? (RAW_W+1)'(1) : span;
    num = {(NUM_W-RAW_W-1)'(0), mag} << (POLARITY_SELECT_I ? BIP_SHIFT : UNI_SHIFT);
    num = num + NUM_W'(den >> 1);
  end

  assign div_start = RAW_VALID_I && !div_busy && state_reg != ST_CAL && !cal_start;
  assign load_word = div_done && owned_reg && state_reg != ST_CAL && !cal_start;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      owned_reg <= 1'b0;
      neg_reg <= 1'b0;
      bip_reg <= 1'b0;
    end else if (cal_start) begin
      owned_reg <= 1'b0;
    end else if (div_start) begin
      owned_reg <= 1'b1;
      neg_reg <= diff[RAW_W];
      bip_reg <= POLARITY_SELECT_I;
    end else if (div_done) begin
      owned_reg <= 1'b0;
    end
  end

  always_comb begin
    if (!bip_reg) begin
      conv_code = neg_reg ? CODE_ZERO
                : (div_sat || div_quot > QUOT_W'(CODE_FULL)) ? CODE_FULL : div_quot[CODE_W-1:0];
    end else if (!neg_reg) begin
      conv_code = (div_sat || div_quot > QUOT_W'(CODE_HALF_MAX)) ? CODE_FULL
                : CODE_MID + div_quot[CODE_W-1:0];
    end else begin
      conv_code = (div_sat || div_quot >= QUOT_W'(CODE_MID)) ? CODE_ZERO
                : CODE_MID - div_quot[CODE_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      WORD_READY_N_O <= 1'b1;
      DATA_O <= CODE_ZERO;
    end else if (cal_start) begin
      WORD_READY_N_O <= 1'b1;
    end else if (cal_end && mode_reg != CAL_SELF) begin
      WORD_READY_N_O <= 1'b0;
      DATA_O <= (mode_reg == CAL_SYS_GAIN) ? CODE_FULL : CODE_ZERO;
    end else if (load_word) begin
      WORD_READY_N_O <= 1'b0;
      DATA_O <= conv_code;
    end
  end

  assign irq_evt[IRQ_CAL_DONE_BIT] = cal_end;
  assign irq_evt[IRQ_NEW_WORD_BIT] = load_word;
  assign irq_evt[IRQ_REJECT_BIT] = ctl.reject;
  assign bus_take = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
  assign bus_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign irq_clr = (bus_wr && AVS_ADDRESS_I == ADDR_IRQ_CLEAR) ? AVS_WRITEDATA_I[IRQ_W-1:0] : '0;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      irq_status_reg <= '0;
      irq_en_reg <= IRQ_EN_RESET;
      IRQ_O <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_evt;
      IRQ_O <= |(irq_status_reg & irq_en_reg);
      if (bus_wr && AVS_ADDRESS_I == ADDR_IRQ_ENABLE) begin
        irq_en_reg <= AVS_WRITEDATA_I[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sw_go_reg <= 1'b0;
      sw_sel_reg <= SW_SEL_RESET;
    end else if (bus_wr && AVS_ADDRESS_I == ADDR_CTRL) begin
      sw_go_reg <= AVS_WRITEDATA_I[CTRL_GO_BIT];
      sw_sel_reg <= {AVS_WRITEDATA_I[CTRL_SEL_FIRST_BIT], AVS_WRITEDATA_I[CTRL_SEL_SECOND_BIT]};
    end else begin
      sw_go_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = '0;
    case (AVS_ADDRESS_I)
      ADDR_CTRL: begin
        rdata_next[CTRL_SEL_FIRST_BIT] = sw_sel_reg[1];
        rdata_next[CTRL_SEL_SECOND_BIT] = sw_sel_reg[0];
      end
      ADDR_STATUS: begin
        rdata_next[ST_BUSY_BIT] = state_reg != ST_RUN;
        rdata_next[ST_WORD_READY_BIT] = WORD_READY_N_O;
        rdata_next[ST_MODE_LSB+1:ST_MODE_LSB] = 2'(mode_reg);
        rdata_next[ST_POL_BIT] = POLARITY_SELECT_I;
      end
      ADDR_DATA: rdata_next[CODE_W-1:0] = DATA_O;
      ADDR_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_status_reg;
      ADDR_IRQ_ENABLE: rdata_next[IRQ_W-1:0] = irq_en_reg;
      ADDR_ZERO_COEF: rdata_next[RAW_W-1:0] = zero_reg;
      ADDR_FULL_COEF: rdata_next[RAW_W-1:0] = full_reg;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= '0;
    end else begin
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
      if (AVS_READ_I && AVS_WAITREQUEST_O) begin
        AVS_READDATA_O <= rdata_next;
      end
    end
  end

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_ready_high_cal: assert property (state_reg == ST_CAL |-> WORD_READY_N_O)
    else $error("Word ready low during calibration");
  a_self_length: assert property (cal_start && start_mode == CAL_SELF |=>
      cal_last_reg == CNT_W'(SELF_CAL_CYCLES - 1) && state_reg == ST_CAL)
    else $error("Self calibration length wrong");
  a_gain_length: assert property (cal_start && start_mode == CAL_SYS_GAIN |=>
      cal_last_reg == CNT_W'(SYS_GAIN_CYCLES - 1) && mode_reg == CAL_SYS_GAIN)
    else $error("System gain length wrong");
  a_self_settles: assert property (cal_end && mode_reg == CAL_SELF |=>
      state_reg == ST_SETTLE && WORD_READY_N_O)
    else $error("Self calibration dropped ready before settling");
  a_system_drop: assert property (cal_end && mode_reg != CAL_SELF |=>
      !WORD_READY_N_O && state_reg == ST_RUN)
    else $error("System step did not drop ready at end");
  a_system_word: assert property (cal_end && mode_reg == CAL_SYS_GAIN |=> DATA_O == CODE_FULL)
    else $error("Gain step did not load all ones");
  a_offset_word: assert property (cal_end && mode_reg == CAL_SYS_OFFSET |=> DATA_O == CODE_ZERO)
    else $error("Offset step did not load all zeros");
  a_code_saturate: assert property (load_word && !bip_reg && !neg_reg && div_sat |=>
      DATA_O == CODE_FULL)
    else $error("Unipolar overrange not saturated");
  a_bipolar_mid: assert property (load_word && bip_reg && div_quot == '0 && !div_sat |=>
      DATA_O == CODE_MID)
    else $error("Bipolar zero not at midscale");
  a_bus_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=>
      !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("Bus answer not after one wait cycle");

  c_self_done: cover property (cal_end && mode_reg == CAL_SELF ##[1:300] load_word);
  c_gain_done: cover property (cal_end && mode_reg == CAL_SYS_GAIN);
  c_new_word: cover property (load_word && state_reg == ST_RUN);
  c_irq: cover property (IRQ_O);
endmodule
`default_nettype wire

//--- cal_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cal_ctrl_if;
  logic start;
  logic reject;
  logic sel_first;
  logic sel_second;
  logic busy;
  modport qualifier (output start, output reject, output sel_first, output sel_second, input busy);
  modport sequencer (input start, input reject, input sel_first, input sel_second, output busy);
endinterface
`default_nettype wire

//--- cal_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cal_host_model (
  input wire logic clk_i,
  output logic trig_o,
  output logic sel_first_o,
  output logic sel_second_o
);
  initial begin
    trig_o = 1'b0;
    sel_first_o = 1'b0;
    sel_second_o = 1'b0;
  end
  task automatic pulse(input logic f, input logic s, input int hi, input logic swap);
    @(posedge clk_i);
    sel_first_o <= f;
    sel_second_o <= s;
    @(posedge clk_i);
    trig_o <= 1'b1;
    @(posedge clk_i);
    if (swap) begin
      sel_first_o <= ~f;
      sel_second_o <= ~s;
    end
    repeat (hi - 1) @(posedge clk_i);
    trig_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- cal_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module cal_trigger
  import adc_cal_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_i,
  input wire logic sel_first_i,
  input wire logic sel_second_i,
  cal_ctrl_if.qualifier ctl
);
  logic trig_d_reg;
  logic [2:0] high_cnt_reg;
  logic rise;
  logic fall;
  logic long_enough;

  assign rise = trig_i && !trig_d_reg;
  assign fall = !trig_i && trig_d_reg;
  assign long_enough = high_cnt_reg >= TRIG_MIN_HIGH;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_cnt_reg <= 3'h0;
    end else if (!trig_i) begin
      high_cnt_reg <= 3'h0;
    end else if (!long_enough) begin
      high_cnt_reg <= high_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl.sel_first <= 1'b0;
      ctl.sel_second <= 1'b0;
    end else if (rise) begin
      ctl.sel_first <= sel_first_i;
      ctl.sel_second <= sel_second_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl.start <= 1'b0;
      ctl.reject <= 1'b0;
    end else begin
      ctl.start <= fall && long_enough && !ctl.busy;
      ctl.reject <= fall && (!long_enough || ctl.busy);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_after_fall: assert property (ctl.start |-> $past(fall) && $past(long_enough))
    else $error("Start without a long enough trigger");
  a_short_ignored: assert property (fall && !long_enough |=> !ctl.start && ctl.reject)
    else $error("Short trigger pulse not ignored");
  a_sel_held: assert property (!rise |=> $stable(ctl.sel_first) && $stable(ctl.sel_second))
    else $error("Selects changed outside trigger rise");
  c_short_pulse: cover property (fall && !long_enough);
endmodule
`default_nettype wire

//--- code_divider.sv
`timescale 1ns/1ps
`default_nettype none
module code_divider
  import adc_cal_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [NUM_W-1:0] num_i,
  input wire logic [RAW_W:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic sat_o,
  output logic [QUOT_W-1:0] quot_o
);
  logic [RAW_W+1:0] rem_reg;
  logic [QUOT_W-1:0] low_reg;
  logic [RAW_W:0] den_reg;
  logic [4:0] step_reg;
  logic [RAW_W+1:0] trial;
  logic fits;

  assign trial = {rem_reg[RAW_W:0], low_reg[QUOT_W-1]};
  assign fits = trial >= {1'b0, den_reg};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_reg <= '0;
      low_reg <= '0;
      den_reg <= '0;
      step_reg <= 5'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      sat_o <= 1'b0;
      quot_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        den_reg <= den_i;
        rem_reg <= num_i[NUM_W-1:QUOT_W];
        low_reg <= num_i[QUOT_W-1:0];
        quot_o <= '0;
        sat_o <= num_i[NUM_W-1:QUOT_W] >= {1'b0, den_i};
        step_reg <= 5'(QUOT_W);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (sat_o || step_reg == 5'h0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          rem_reg <= fits ? trial - {1'b0, den_reg} : trial;
          low_reg <= {low_reg[QUOT_W-2:0], 1'b0};
          quot_o <= {quot_o[QUOT_W-2:0], fits};
          step_reg <= step_reg - 5'h1;
        end
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_div_bounded: assert property (start_i && !busy_o |=> busy_o ##[1:23] done_o)
    else $error("Conversion divide did not finish in time");
endmodule
`default_nettype wire

//--- test_adc_calibration_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_sequencer;
  import adc_cal_pkg::*;
  localparam int N_SELF = 40;
  localparam int N_OFF = 20;
  localparam int N_GAIN = 24;
  localparam int N_ONE = 30;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pol = 1'b0;
  logic raw_on = 1'b0;
  logic raw_valid = 1'b0;
  logic [19:0] r_val = 20'h0;
  logic [23:0] raw;
  logic trig, sf, ss, wait_o, wr_n, irq;
  logic [7:0] addr = 8'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [19:0] data;
  logic [1:0] insel;
  logic [3:0] tick = 4'h0;
  logic [31:0] xs = 32'h81add81f;
  int error_cnt = 0;
  int checks = 0;
  int hi_cnt = 0;
  int lo_v, hi_v;
  logic [19:0] exp_q[$];
  int min_q[$];
  int max_q[$];
  logic [1:0] sel_t[3] = '{2'h3, 2'h1, 2'h2};
  int len_t[3] = '{N_OFF, N_GAIN, N_ONE};
  logic [19:0] code_t[3] = '{CODE_ZERO, CODE_FULL, CODE_ZERO};

  always #25 clk = ~clk;
  assign raw = (insel == INSEL_ANALOG_GROUND_LEVEL) ? 24'h0 :
               (insel == INSEL_REF) ? 24'h100000 : {4'h0, r_val};

  cal_host_model cal_host_model_inst (.clk_i(clk), .trig_o(trig), .sel_first_o(sf),
    .sel_second_o(ss));
  adc_calibration_sequencer #(.SELF_CAL_CYCLES(N_SELF), .SYS_OFFSET_CYCLES(N_OFF),
    .SYS_GAIN_CYCLES(N_GAIN), .ONE_STEP_CYCLES(N_ONE)) adc_calibration_sequencer_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .CAL_TRIGGER_I(trig), .CAL_SELECT_FIRST_I(sf),
    .CAL_SELECT_SECOND_I(ss), .POLARITY_SELECT_I(pol), .RAW_DATA_I(raw),
    .RAW_VALID_I(raw_valid), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .WORD_READY_N_O(wr_n), .DATA_O(data),
    .INPUT_SEL_O(insel), .IRQ_O(irq));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic drain();
    repeat (600) if (exp_q.size() != 0) @(posedge clk);
    check(exp_q.size(), 0);
  endtask

  always @(posedge clk) begin
    tick <= tick + 4'h1;
    raw_valid <= raw_on && (tick == 4'h0);
  end

  // Word ready fall: compare code and high time
  always @(posedge clk) begin
    if (!rst && wr_n === 1'b1) hi_cnt <= hi_cnt + 1;
    if (!rst && wr_n === 1'b0 && hi_cnt > 0) begin
      hi_cnt <= 0;
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        lo_v = min_q.pop_front();
        hi_v = max_q.pop_front();
        check({12'h0, data}, {12'h0, exp_q.pop_front()});
        check(hi_cnt >= lo_v && hi_cnt <= hi_v, 1);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    logic [31:0] q;
    logic [20:0] bip_e;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cal_host_model_inst.pulse(1'b0, 1'b0, 3, 1'b0);
    repeat (8) @(posedge clk);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
    check(q, 32'h4);
    check({31'h0, irq}, 32'h0);
    check({31'h0, wr_n}, 32'h1);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h1, q);
    bus(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    xs = xorshift(xs);
    r_val <= xs[19:0];
    raw_on <= 1'b1;
    exp_q.push_back(xs[19:0]);
    min_q.push_back(N_SELF);
    max_q.push_back(1000);
    cal_host_model_inst.pulse(1'b0, 1'b0, 4, 1'b0);
    drain();
    // Bipolar coding of the same input after self calibration
    pol <= 1'b1;
    repeat (64) @(posedge clk);
    bip_e = ({1'b0, r_val} + 21'h1) >> 1;
    bus(1'b0, ADDR_DATA, 32'h0, q);
    check(q, (bip_e > 21'h7ffff) ? 32'hfffff : {12'h0, CODE_MID + bip_e[19:0]});
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q, 32'h10);
    pol <= 1'b0;
    raw_on <= 1'b0;
    check({31'h0, irq}, 32'h1);
    bus(1'b1, ADDR_IRQ_CLEAR, 32'h7, q);
    repeat (4) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(code_t[i]);
      min_q.push_back(len_t[i]);
      max_q.push_back(len_t[i] + 4);
      cal_host_model_inst.pulse(sel_t[i][1], sel_t[i][0], 4, i == 0);
      drain();
    end
    // Software start of a gain step
    exp_q.push_back(CODE_FULL);
    min_q.push_back(N_GAIN);
    max_q.push_back(N_GAIN + 4);
    bus(1'b1, ADDR_CTRL, 32'h3, q);
    drain();
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    check(q, 32'h2);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q, 32'h8);
    stop_test();
  end
endmodule
`default_nettype wire
